// ===== verilog/frpc_top.sv
// flash erase and row program sequencer with axi4-lite register slave
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`include "frpc_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module frpc_top #(
    parameter int unsigned ROW_CYCLES = `FRPC_ROW_TIME_US * `FRPC_CLK_MHZ,
    parameter int unsigned PAGE_CYCLES = `FRPC_PAGE_TIME_US * `FRPC_CLK_MHZ
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    output logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    input wire logic [7:0] s_axi_araddr_in,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic cpu_stall_out,
    output logic flash_busy_out,
    output logic [1:0] flash_op_out,
    output logic [15:0] flash_row_out
);
    localparam int unsigned WORD_CYCLES = `FRPC_WORD_TIME_US * `FRPC_CLK_MHZ;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;

    // byte-enable merge of a 16-bit field
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] be);
        merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
    endfunction

    // registers
    logic aw_got_ff, nxt_aw_got;
    logic w_got_ff, nxt_w_got;
    logic [7:0] aw_addr_ff, nxt_aw_addr;
    logic [31:0] w_data_ff, nxt_w_data;
    logic [3:0] w_strb_ff, nxt_w_strb;
    logic bvalid_ff, nxt_bvalid;
    logic [1:0] bresp_ff, nxt_bresp;
    logic rvalid_ff, nxt_rvalid;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [1:0] rresp_ff, nxt_rresp;
    logic start_ff, nxt_start;
    logic enable_ff, nxt_enable;
    logic error_ff, nxt_error;
    logic erase_ff, nxt_erase;
    logic [3:0] opsel_ff, nxt_opsel;
    logic [15:0] page_ff, nxt_page;
    logic [15:0] haddr_ff, nxt_haddr;
    logic [15:0] hlow_ff, nxt_hlow;
    logic [6:0] hcount_ff, nxt_hcount;
    frpc_pkg::frpc_key_t key_ff, nxt_key;
    frpc_pkg::frpc_op_t op_ff, nxt_op;
    logic [19:0] timer_ff, nxt_timer;
    logic [23:0] buf_mem [0:`FRPC_ROW_WORDS-1];
    logic buf_we;
    logic [5:0] buf_idx;
    logic awready_ff, wready_ff, arready_ff;

    logic wr_fire;
    logic [15:0] ctl_read;
    assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
    assign ctl_read = {start_ff, enable_ff, error_ff, 6'h00, erase_ff, 2'h0, opsel_ff};

    // decodes an op request from the merged control write
    function automatic frpc_pkg::frpc_op_t decode_op(input logic er, input logic [3:0] op);
        if (er && op == `FRPC_OP_PAGE) decode_op = frpc_pkg::frpc_page;
        else if (!er && op == `FRPC_OP_ROW) decode_op = frpc_pkg::frpc_row;
        else if (!er && op == `FRPC_OP_WORD) decode_op = frpc_pkg::frpc_word;
        else decode_op = frpc_pkg::frpc_none;
    endfunction

    // bus handshake, register writes, key sequence and operation timer
    always_comb begin
        logic [15:0] cw;
        frpc_pkg::frpc_op_t req;
        cw = 16'h0000;
        req = frpc_pkg::frpc_none;
        nxt_aw_got = aw_got_ff;
        nxt_w_got = w_got_ff;
        nxt_aw_addr = aw_addr_ff;
        nxt_w_data = w_data_ff;
        nxt_w_strb = w_strb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        nxt_start = start_ff;
        nxt_enable = enable_ff;
        nxt_error = error_ff;
        nxt_erase = erase_ff;
        nxt_opsel = opsel_ff;
        nxt_page = page_ff;
        nxt_haddr = haddr_ff;
        nxt_hlow = hlow_ff;
        nxt_hcount = hcount_ff;
        nxt_key = key_ff;
        nxt_op = op_ff;
        nxt_timer = timer_ff;
        buf_we = 1'b0;
        buf_idx = haddr_ff[5:0];
        // beats move only on valid and ready; ready is still low at the first edge after reset
        if (s_axi_awvalid_in && awready_ff) begin
            nxt_aw_got = 1'b1;
            nxt_aw_addr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && wready_ff) begin
            nxt_w_got = 1'b1;
            nxt_w_data = s_axi_wdata_in;
            nxt_w_strb = s_axi_wstrb_in;
        end
        if (bvalid_ff && s_axi_bready_in) nxt_bvalid = 1'b0;
        // busy timer; the cpu stays stalled until it expires
        if (op_ff != frpc_pkg::frpc_none) begin
            if (timer_ff == 20'h00000) begin
                nxt_op = frpc_pkg::frpc_none;
                nxt_start = 1'b0;
                if (op_ff == frpc_pkg::frpc_row) nxt_hcount = 7'h00;
            end else begin
                nxt_timer = timer_ff - 20'h00001;
            end
        end
        // writes are held off while busy, as the stalled cpu cannot issue them
        if (wr_fire && op_ff == frpc_pkg::frpc_none) begin
            nxt_aw_got = 1'b0;
            nxt_w_got = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = RESP_OK;
            nxt_key = frpc_pkg::frpc_idle;
            unique case (aw_addr_ff)
                `FRPC_OFS_CONTROL: begin
                    cw = merge16(ctl_read, w_data_ff, w_strb_ff);
                    nxt_enable = cw[`FRPC_BIT_ENABLE];
                    nxt_erase = cw[`FRPC_BIT_ERASE];
                    nxt_opsel = cw[3:0];
                    // error is writable so software can clear it; a set attempt below wins
                    nxt_error = cw[`FRPC_BIT_ERROR];
                    if (cw[`FRPC_BIT_START] && !start_ff) begin
                        req = decode_op(cw[`FRPC_BIT_ERASE], cw[3:0]);
                        if (key_ff == frpc_pkg::frpc_armed && cw[`FRPC_BIT_ENABLE]
                            && req != frpc_pkg::frpc_none) begin
                            nxt_start = 1'b1;
                            nxt_op = req;
                            if (req == frpc_pkg::frpc_page) nxt_timer = 20'(PAGE_CYCLES - 1);
                            else if (req == frpc_pkg::frpc_row) nxt_timer = 20'(ROW_CYCLES - 1);
                            else nxt_timer = 20'(WORD_CYCLES - 1);
                        end else begin
                            nxt_error = 1'b1;
                        end
                    end
                end
                `FRPC_OFS_KEY: begin
                    if (w_strb_ff[0] && w_data_ff[7:0] == `FRPC_KEY_FIRST)
                        nxt_key = frpc_pkg::frpc_key1;
                    else if (w_strb_ff[0] && key_ff == frpc_pkg::frpc_key1
                             && w_data_ff[7:0] == `FRPC_KEY_SECOND)
                        nxt_key = frpc_pkg::frpc_armed;
                end
                `FRPC_OFS_PAGE: nxt_page = merge16(page_ff, w_data_ff, w_strb_ff);
                `FRPC_OFS_HOLD_ADDR: nxt_haddr = merge16(haddr_ff, w_data_ff, w_strb_ff);
                `FRPC_OFS_HOLD_LOW: nxt_hlow = merge16(hlow_ff, w_data_ff, w_strb_ff);
                `FRPC_OFS_HOLD_HIGH: begin
                    // high byte completes the instruction and post-increments the pointer
                    buf_we = 1'b1;
                    nxt_haddr = haddr_ff + 16'h0001;
                    if (hcount_ff != 7'(`FRPC_ROW_WORDS)) nxt_hcount = hcount_ff + 7'h01;
                end
                `FRPC_OFS_STATUS: ;
                default: nxt_bresp = RESP_ERR;
            endcase
        end
        // reads answer one cycle after the address is taken
        if (rvalid_ff && s_axi_rready_in) nxt_rvalid = 1'b0;
        if (s_axi_arvalid_in && arready_ff) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = RESP_OK;
            nxt_rdata = 32'h00000000;
            unique case (s_axi_araddr_in)
                `FRPC_OFS_CONTROL: nxt_rdata = {16'h0000, ctl_read};
                `FRPC_OFS_STATUS: nxt_rdata = {23'h000000, op_ff != frpc_pkg::frpc_none,
                                               1'b0, hcount_ff};
                `FRPC_OFS_PAGE: nxt_rdata = {16'h0000, page_ff};
                `FRPC_OFS_HOLD_ADDR: nxt_rdata = {16'h0000, haddr_ff};
                `FRPC_OFS_HOLD_LOW: nxt_rdata = {16'h0000, hlow_ff};
                `FRPC_OFS_KEY, `FRPC_OFS_HOLD_HIGH: ; // write-only, read as zero
                default: nxt_rresp = RESP_ERR;
            endcase
        end
    end

    // state registers
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_data_ff <= 32'h00000000;
            w_strb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= 2'h0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= 2'h0;
            {start_ff, enable_ff, error_ff, erase_ff} <= 4'h0;
            opsel_ff <= 4'h0;
            page_ff <= 16'h0000;
            haddr_ff <= 16'h0000;
            hlow_ff <= 16'h0000;
            hcount_ff <= 7'h00;
            key_ff <= frpc_pkg::frpc_idle;
            op_ff <= frpc_pkg::frpc_none;
            timer_ff <= 20'h00000;
        end else begin
            aw_got_ff <= nxt_aw_got;
            w_got_ff <= nxt_w_got;
            aw_addr_ff <= nxt_aw_addr;
            w_data_ff <= nxt_w_data;
            w_strb_ff <= nxt_w_strb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
            start_ff <= nxt_start;
            enable_ff <= nxt_enable;
            error_ff <= nxt_error;
            erase_ff <= nxt_erase;
            opsel_ff <= nxt_opsel;
            page_ff <= nxt_page;
            haddr_ff <= nxt_haddr;
            hlow_ff <= nxt_hlow;
            hcount_ff <= nxt_hcount;
            key_ff <= nxt_key;
            op_ff <= nxt_op;
            timer_ff <= nxt_timer;
        end
    end

    // holding buffer of one row; no reset, contents are loaded before use
    always_ff @(posedge clk_in) begin
        if (buf_we) buf_mem[buf_idx] <= {w_data_ff[7:0], hlow_ff};
    end

    // axi ready is registered: low while a beat is held or a read response is pending
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            {awready_ff, wready_ff, arready_ff} <= 3'h0;
        end else begin
            awready_ff <= !nxt_aw_got;
            wready_ff <= !nxt_w_got;
            arready_ff <= !nxt_rvalid;
        end
    end

    always_comb begin
        s_axi_awready_out = awready_ff;
        s_axi_wready_out = wready_ff;
        s_axi_arready_out = arready_ff;
        s_axi_bvalid_out = bvalid_ff;
        s_axi_bresp_out = bresp_ff;
        s_axi_rvalid_out = rvalid_ff;
        s_axi_rdata_out = rdata_ff;
        s_axi_rresp_out = rresp_ff;
        cpu_stall_out = start_ff;
        flash_busy_out = start_ff;
        flash_op_out = op_ff;
        flash_row_out = page_ff;
    end
endmodule // frpc_top
`default_nettype wire

// ===== verilog/frpc_cfg.svh
// timing, offsets, field positions and reset values of the flash control block
`ifndef FRPC_CFG_SVH
`define FRPC_CFG_SVH
`define FRPC_OFS_CONTROL 8'h00
`define FRPC_OFS_KEY 8'h04
`define FRPC_OFS_STATUS 8'h08
`define FRPC_OFS_HOLD_ADDR 8'h0c
`define FRPC_OFS_HOLD_LOW 8'h10
`define FRPC_OFS_HOLD_HIGH 8'h14
`define FRPC_OFS_PAGE 8'h18
`define FRPC_BIT_START 15
`define FRPC_BIT_ENABLE 14
`define FRPC_BIT_ERROR 13
`define FRPC_BIT_ERASE 6
`define FRPC_CONTROL_RESET 16'h0000
`define FRPC_KEY_FIRST 8'h55
`define FRPC_KEY_SECOND 8'haa
`define FRPC_OP_ROW 4'h1
`define FRPC_OP_PAGE 4'h2
`define FRPC_OP_WORD 4'h3
`define FRPC_ROW_WORDS 64
`define FRPC_PAGE_ROWS 8
`define FRPC_PAGE_WORDS 512
`define FRPC_ROW_TIME_US 1500
`define FRPC_PAGE_TIME_US 20000
`define FRPC_WORD_TIME_US 50
`define FRPC_CLK_MHZ 20
`endif

// ===== verilog/frpc_pkg.sv
// types of the flash control block
package frpc_pkg;
    typedef enum logic [1:0] {
        frpc_idle,
        frpc_key1,
        frpc_armed
    } frpc_key_t;
    typedef enum logic [1:0] {
        frpc_none,
        frpc_row,
        frpc_page,
        frpc_word
    } frpc_op_t;
endpackage

// ===== testbench/frpc_chk_properties.sv
// concurrent checks on the flash control block ports
`timescale 1ns/1ns
`default_nettype none
module frpc_chk #(
    parameter int unsigned ROW_CYCLES = 20,
    parameter int unsigned PAGE_CYCLES = 40
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic s_axi_rvalid_out,
    input wire logic cpu_stall_out,
    input wire logic flash_busy_out,
    input wire logic [1:0] flash_op_out
);
    logic wr, vop, go_ok, ok_ff;
    logic [1:0] key_ff, exp_ff;
    int unsigned cnt_ff;
    // a write counts only when aw and w are both taken in the same cycle
    assign wr = s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
    assign vop = s_axi_wdata_in[6] ? s_axi_wdata_in[3:0] == 4'h2
        : s_axi_wdata_in[3:0] inside {4'h1, 4'h3};
    assign go_ok = wr && s_axi_awaddr_in == 8'h00 && s_axi_wdata_in[15] && s_axi_wdata_in[14]
        && vop && key_ff == 2'h2;
    // shadow of the unlock; any other write in between drops it back
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            key_ff <= 2'h0;
            ok_ff <= 1'b0;
            exp_ff <= 2'h0;
            cnt_ff <= 0;
        end else begin
            cnt_ff <= cpu_stall_out ? cnt_ff + 1 : 0;
            if (wr) begin
                key_ff <= s_axi_awaddr_in != 8'h04 ? 2'h0 : s_axi_wdata_in[7:0] == 8'h55 ? 2'h1 :
                    (s_axi_wdata_in[7:0] == 8'haa && key_ff == 2'h1) ? 2'h2 : 2'h0;
                ok_ff <= go_ok;
                exp_ff <= s_axi_wdata_in[6] ? 2'h2 : s_axi_wdata_in[1:0];
            end
        end
    end
    default clocking dc @(posedge clk_in); endclocking
    default disable iff (reset_in);
    property p_busy_eq; flash_busy_out == cpu_stall_out; endproperty
    a_busy_eq: assert property (p_busy_eq) else $error("busy and stall differ");
    property p_op_busy; cpu_stall_out == (flash_op_out != 2'h0); endproperty
    a_op_busy: assert property (p_op_busy) else $error("op code and stall differ");
    property p_start_unlocked; $rose(cpu_stall_out) |-> ok_ff; endproperty
    a_start_unlocked: assert property (p_start_unlocked)
        else $error("start without unlock");
    property p_op_kind; $rose(cpu_stall_out) |-> flash_op_out == exp_ff; endproperty
    a_op_kind: assert property (p_op_kind) else $error("wrong operation launched");
    property p_launch; go_ok |-> ##[1:3] cpu_stall_out; endproperty
    a_launch: assert property (p_launch) else $error("valid start not launched");
    // the stall spans exactly the configured cycle count
    property p_row_len;
        $fell(cpu_stall_out) && $past(flash_op_out) == 2'h1 |-> cnt_ff == ROW_CYCLES;
    endproperty
    a_row_len: assert property (p_row_len) else $error("row program length wrong");
    property p_page_len;
        $fell(cpu_stall_out) && $past(flash_op_out) == 2'h2 |-> cnt_ff == PAGE_CYCLES;
    endproperty
    a_page_len: assert property (p_page_len) else $error("page erase length wrong");
    property p_rd_stall;
        cpu_stall_out && s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out;
    endproperty
    a_rd_stall: assert property (p_rd_stall) else $error("read not answered while held");
endmodule // frpc_chk
bind frpc_top frpc_chk #(.ROW_CYCLES(ROW_CYCLES), .PAGE_CYCLES(PAGE_CYCLES)) chk_i (
    .clk_in(clk_in), .reset_in(reset_in), .s_axi_awvalid_in(s_axi_awvalid_in),
    .s_axi_awready_out(s_axi_awready_out), .s_axi_awaddr_in(s_axi_awaddr_in),
    .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
    .s_axi_wdata_in(s_axi_wdata_in), .s_axi_arvalid_in(s_axi_arvalid_in),
    .s_axi_arready_out(s_axi_arready_out), .s_axi_rvalid_out(s_axi_rvalid_out),
    .cpu_stall_out(cpu_stall_out), .flash_busy_out(flash_busy_out), .flash_op_out(flash_op_out));
`default_nettype wire

// ===== testbench/frpc_cpu_model.sv
// processor side model: measures how long each operation holds it
`timescale 1ns/1ns
`default_nettype none
module frpc_cpu_model (
    input wire logic clk_in,
    input wire logic stall_in,
    output var int stall_len_out
);
    int cnt = 0;
    // a held cpu issues nothing, so the no-ops and the full wait come for free
    always @(posedge clk_in) begin
        if (stall_in) begin
            cnt <= cnt + 1;
        end else if (cnt != 0) begin
            stall_len_out <= cnt;
            cnt <= 0;
        end
    end
endmodule // frpc_cpu_model
`default_nettype wire

// ===== testbench/frpc_tb.sv
// self-checking bench for the flash control block
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam int unsigned ROW = 20;
    localparam int unsigned PAGE = 40;
    logic clk_in = 1'b0, reset_in = 1'b1, awv = 1'b0, wv = 1'b0;
    logic bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic awr, wrdy, bv, arr, rv, stall, busy;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rdata;
    logic [1:0] bresp, rresp, fop;
    logic [15:0] frow;
    int n_fail = 0, samples_checked = 0, slen;
    frpc_top #(.ROW_CYCLES(ROW), .PAGE_CYCLES(PAGE)) dut (.clk_in(clk_in), .reset_in(reset_in),
        .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_awaddr_in(awa),
        .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf),
        .s_axi_bvalid_out(bv), .s_axi_bready_in(bready), .s_axi_bresp_out(bresp),
        .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_araddr_in(ara),
        .s_axi_rvalid_out(rv), .s_axi_rready_in(rready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .cpu_stall_out(stall), .flash_busy_out(busy),
        .flash_op_out(fop), .flash_row_out(frow));
    frpc_cpu_model cpu (.clk_in(clk_in), .stall_in(stall), .stall_len_out(slen));
    initial begin
        forever #25 clk_in = ~clk_in;
    end
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // write: aw and w offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        awv <= 1'b1;
        wv <= 1'b1;
        awa <= a;
        wd <= d;
        bready <= 1'b1;
        do begin
            @(posedge clk_in);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end while (bv !== 1'b1);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        @(posedge clk_in);
        arv <= 1'b1;
        ara <= a;
        rready <= 1'b1;
        do begin
            @(posedge clk_in);
            if (arr) arv <= 1'b0;
        end while (rv !== 1'b1);
        rready <= 1'b0;
        chk({rresp, rdata}, e);
    endtask
    // mode 0 proper unlock, 1 no keys, 2 write between keys, 3 write after keys
    task automatic go(input int m, input logic [31:0] c, input logic [33:0] e);
        wr(8'h00, 32'h0);
        if (m != 1) wr(8'h04, 32'h55);
        if (m == 2) wr(8'h18, 32'h7);
        if (m != 1) wr(8'h04, 32'haa);
        if (m == 3) wr(8'h18, 32'h7);
        wr(8'h00, c);
        // a stalled cpu issues nothing until the operation ends
        while (stall !== 1'b0) @(posedge clk_in);
        rd(8'h00, e);
        $display("test ctrl %h mode %0d done", c, m);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (10000) @(posedge clk_in);
        n_fail++;
        test_done;
    end
    // main sequence
    initial begin
        repeat (3) @(posedge clk_in);
        reset_in <= 1'b0;
        rd(8'h00, 34'h0);
        rd(8'h40, {2'h2, 32'h0});
        rd(8'h04, 34'h0);
        wr(8'h40, 32'h1);
        chk({32'h0, bresp}, 34'h2);
        wr(8'h18, 32'h5);
        chk({16'h0, bresp, frow}, 34'h5);
        $display("test registers done");
        wr(8'h00, 32'h4042);
        wr(8'h04, 32'h55);
        wr(8'h04, 32'haa);
        fork
            wr(8'h00, 32'hc042);
            begin
                repeat (6) @(posedge clk_in);
                rd(8'h08, 34'h100);
            end
        join
        // control is read once the erase ends; the status read above is answered during the stall
        while (stall !== 1'b0) @(posedge clk_in);
        rd(8'h00, 34'h4042);
        chk(34'(slen), 34'(PAGE));
        $display("test page erase done");
        // two rows in turn, advancing the table page each time
        for (int r = 0; r < 2; r++) begin
            wr(8'h18, 32'(5 + r));
            wr(8'h0c, 32'h0);
            for (int i = 0; i < 64; i++) begin
                wr(8'h10, 32'(i));
                wr(8'h14, 32'(i));
            end
            rd(8'h08, 34'h40);
            go(0, 32'hc001, 34'h4001);
            chk(34'(slen), 34'(ROW));
            chk({18'h0, frow}, 34'(5 + r));
        end
        go(0, 32'hc003, 34'h4003);
        chk(34'(slen), 34'h3e8);
        go(1, 32'hc001, 34'h6001);
        go(2, 32'hc001, 34'h6001);
        go(3, 32'hc001, 34'h6001);
        go(0, 32'h8001, 34'h2001);
        go(0, 32'hc041, 34'h6041);
        go(0, 32'hc002, 34'h6002);
        chk(34'(slen), 34'h3e8);
        test_done;
    end
endmodule // testbench
`default_nettype wire
